// >>> design/timer16_capture_compare_ctrl.sv
// 16-bit timer/counter with capture, compare, waveform modes and an APB register file.
//
// Local design decision: the APB interface to the registers.
`timescale 1ns/100ps
module timer16_capture_compare_ctrl (
	input wire logic clk,
	input wire logic rst,
	input wire timer16_pkg::apb_req_t apbReq,
	output timer16_pkg::apb_rsp_t apbRsp,
	input wire logic capture_input_pin,
	input wire logic ext_count_pin,
	input wire logic globalIntEn,
	output logic compare_output_a,
	output logic compare_output_b,
	output logic compare_output_c,
	output logic [2:0] compareOutEn,
	output logic intRequest
);
	// ==========================================================
	// Helper functions
	function automatic logic prescTick(input logic [2:0] sel, input logic [9:0] p,
		input logic prevPin, input logic nowPin);
		case (sel)
			timer16_pkg::CS_DIV1: prescTick = 1'b1;
			timer16_pkg::CS_DIV8: prescTick = &p[2:0];
			timer16_pkg::CS_DIV64: prescTick = &p[5:0];
			timer16_pkg::CS_DIV256: prescTick = &p[7:0];
			timer16_pkg::CS_DIV1024: prescTick = &p;
			timer16_pkg::CS_EXT_FALL: prescTick = prevPin & ~nowPin;
			timer16_pkg::CS_EXT_RISE: prescTick = ~prevPin & nowPin;
			default: prescTick = 1'b0;
		endcase
	endfunction : prescTick

	function automatic logic [15:0] topOf(input logic [3:0] m, input logic [15:0] ocra,
		input logic [15:0] icr);
		case (m)
			4'h1, 4'h5: topOf = timer16_pkg::TOP_8;
			4'h2, 4'h6: topOf = timer16_pkg::TOP_9;
			4'h3, 4'h7: topOf = timer16_pkg::TOP_10;
			4'h4, 4'h9, 4'hb, 4'hc, 4'hf: topOf = ocra;
			4'h8, 4'ha, 4'he: topOf = icr;
			default: topOf = timer16_pkg::TOP_MAX;
		endcase
	endfunction : topOf

	function automatic logic applyCom(input logic [1:0] com, input logic cur);
		case (com)
			2'h1: applyCom = ~cur;
			2'h2: applyCom = 1'b0;
			2'h3: applyCom = 1'b1;
			default: applyCom = cur;
		endcase
	endfunction : applyCom

	function automatic logic pwmLevel(input logic [1:0] com, input logic cur, input logic lvl);
		pwmLevel = com[1] ? (com[0] ? ~lvl : lvl) : cur;
	endfunction : pwmLevel

	// ==========================================================
	// State
	logic [7:0] ctrlA;
	logic [7:0] ctrlB;
	logic [7:0] intEn;
	logic [7:0] flags;
	logic [7:0] temp;
	logic [7:0] snapHigh;
	logic [15:0] counter;
	logic [15:0] capValue;
	logic [15:0] cmpVal [3];
	logic [9:0] presc;
	logic extPrev;
	logic capPrev;
	logic [3:0] capHist;
	logic capFilt;
	logic blockMatch;
	logic countUp;
	logic [2:0] waveLevel;
	logic [15:0] next_counter;
	logic next_countUp;
	logic [2:0] next_wave;

	// ==========================================================
	// APB decode
	wire setupPhase = apbReq.psel & ~apbReq.penable;
	wire accessEdge = apbReq.psel & apbReq.penable & apbRsp.pready;
	wire [7:0] idx = apbReq.paddr[9:2];
	wire [7:0] wbyte = apbReq.pwdata[7:0];
	wire idxKnown = (idx == timer16_pkg::IDX_FLAGS) || (idx == timer16_pkg::IDX_INT_EN) ||
		(idx >= timer16_pkg::IDX_CTRL_A && idx <= timer16_pkg::IDX_FORCE) ||
		(idx >= timer16_pkg::IDX_CNT_L && idx <= timer16_pkg::IDX_CMPC_H);
	wire mapped = idxKnown && (apbReq.paddr[11:10] == 2'h0) && (apbReq.paddr[1:0] == 2'h0);
	wire wrEn = accessEdge & apbReq.pwrite & mapped;
	wire rdEn = accessEdge & ~apbReq.pwrite & mapped;
	wire wrCtrlA = wrEn && idx == timer16_pkg::IDX_CTRL_A;
	wire wrCtrlB = wrEn && idx == timer16_pkg::IDX_CTRL_B;
	wire wrForce = wrEn && idx == timer16_pkg::IDX_FORCE;
	wire wrFlags = wrEn && idx == timer16_pkg::IDX_FLAGS;
	wire wrIntEn = wrEn && idx == timer16_pkg::IDX_INT_EN;
	wire wrCntL = wrEn && idx == timer16_pkg::IDX_CNT_L;
	wire wrCapL = wrEn && idx == timer16_pkg::IDX_CAP_L;
	wire wrCmpAL = wrEn && idx == timer16_pkg::IDX_CMPA_L;
	wire wrCmpBL = wrEn && idx == timer16_pkg::IDX_CMPB_L;
	wire wrCmpCL = wrEn && idx == timer16_pkg::IDX_CMPC_L;
	// Every high-byte write lands in the one shared latch.
	wire wrHigh = wrEn && (idx == timer16_pkg::IDX_CNT_H || idx == timer16_pkg::IDX_CAP_H ||
		idx == timer16_pkg::IDX_CMPA_H || idx == timer16_pkg::IDX_CMPB_H ||
		idx == timer16_pkg::IDX_CMPC_H);
	wire rdLatchLow = rdEn && (idx == timer16_pkg::IDX_CNT_L || idx == timer16_pkg::IDX_CAP_L);

	// ==========================================================
	// Read selection
	wire [7:0] readByte =
		(idx == timer16_pkg::IDX_FLAGS) ? flags :
		(idx == timer16_pkg::IDX_INT_EN) ? intEn :
		(idx == timer16_pkg::IDX_CTRL_A) ? ctrlA :
		(idx == timer16_pkg::IDX_CTRL_B) ? (ctrlB & timer16_pkg::CTRL_B_WMASK) :
		(idx == timer16_pkg::IDX_CNT_L) ? counter[7:0] :
		(idx == timer16_pkg::IDX_CNT_H) ? temp :
		(idx == timer16_pkg::IDX_CAP_L) ? capValue[7:0] :
		(idx == timer16_pkg::IDX_CAP_H) ? temp :
		(idx == timer16_pkg::IDX_CMPA_L) ? cmpVal[0][7:0] :
		(idx == timer16_pkg::IDX_CMPA_H) ? cmpVal[0][15:8] :
		(idx == timer16_pkg::IDX_CMPB_L) ? cmpVal[1][7:0] :
		(idx == timer16_pkg::IDX_CMPB_H) ? cmpVal[1][15:8] :
		(idx == timer16_pkg::IDX_CMPC_L) ? cmpVal[2][7:0] :
		(idx == timer16_pkg::IDX_CMPC_H) ? cmpVal[2][15:8] :
		timer16_pkg::BYTE_RESET;
	wire [7:0] highOfLow = (idx == timer16_pkg::IDX_CAP_L) ? capValue[15:8] : counter[15:8];

	// ==========================================================
	// Mode and clock decode
	wire [3:0] mode = {ctrlB[4:3], ctrlA[1:0]};
	wire [2:0] clkSel = ctrlB[2:0];
	wire pwmMode = !(mode == 4'h0 || mode == 4'h4 || mode == 4'hc || mode == 4'hd);
	wire phaseMode = (mode >= 4'h1 && mode <= 4'h3) || (mode >= 4'h8 && mode <= 4'hb);
	wire capDisabled = (mode == 4'h8) || (mode == 4'ha) || (mode == 4'he);
	wire [15:0] top = topOf(mode, cmpVal[0], capValue);
	// The pin is read as an input whatever drives it, so software may clock the count.
	wire tick = prescTick(clkSel, presc, extPrev, ext_count_pin);

	// ==========================================================
	// Input capture
	wire filterOn = ctrlB[timer16_pkg::FILTER_EN_POS];
	wire edgeLevel = ctrlB[timer16_pkg::EDGE_SEL_POS];
	wire rawEdge = ctrlB[timer16_pkg::EDGE_SEL_POS] ?
		(capture_input_pin & ~capPrev) : (~capture_input_pin & capPrev);
	wire filtRise = (capHist == 4'hf) & ~capFilt;
	wire filtFall = (capHist == 4'h0) & capFilt;
	wire filtEdge = ctrlB[timer16_pkg::EDGE_SEL_POS] ? filtRise : filtFall;
	wire capEvent = ~capDisabled &
		(ctrlB[timer16_pkg::FILTER_EN_POS] ? filtEdge : rawEdge);

	// ==========================================================
	// Counter
	always_comb begin
		next_counter = counter;
		next_countUp = countUp;
		if (wrCntL) begin
			next_counter = {temp, wbyte};
		end else if (tick) begin
			if (phaseMode) begin
				if (countUp && counter >= top) begin
					next_countUp = 1'b0;
					next_counter = counter - 16'h0001;
				end else if (!countUp && counter == 16'h0000) begin
					next_countUp = 1'b1;
					next_counter = 16'h0001;
				end else begin
					next_counter = countUp ? counter + 16'h0001 : counter - 16'h0001;
				end
			end else if (counter == top) begin
				next_counter = 16'h0000;
			end else begin
				next_counter = counter + 16'h0001;
			end
		end
	end

	wire overflow = tick & ~wrCntL & (phaseMode ? (~countUp & counter == 16'h0000) :
		(counter == (pwmMode ? top : timer16_pkg::TOP_MAX)));
	wire wrapHit = tick & pwmMode & ~phaseMode & (counter == top);

	// ==========================================================
	// Compare channels
	wire [2:0] cmpHit;
	wire [2:0] forceHit;
	genvar ch;
	for (ch = 0; ch < 3; ch++) begin : g_chan
		wire [1:0] com = ctrlA[7 - 2 * ch -: 2];
		assign cmpHit[ch] = tick & ~blockMatch & ~wrCntL & (counter == cmpVal[ch]);
		assign forceHit[ch] = wrForce & wbyte[timer16_pkg::FORCE_TOP_POS - ch] & ~pwmMode;
		assign next_wave[ch] =
			!pwmMode ? ((cmpHit[ch] | forceHit[ch]) ? applyCom(com, waveLevel[ch]) :
				waveLevel[ch]) :
			phaseMode ? (cmpHit[ch] ? pwmLevel(com, waveLevel[ch], ~countUp) : waveLevel[ch]) :
			cmpHit[ch] ? pwmLevel(com, waveLevel[ch], 1'b0) :
			wrapHit ? pwmLevel(com, waveLevel[ch], 1'b1) : waveLevel[ch];
	end

	// Forced strobes are absent from the flag set terms, so they raise nothing.
	wire [7:0] flagSet = ({7'h00, capEvent} << timer16_pkg::FLAG_CAP) |
		({5'h00, cmpHit} << timer16_pkg::FLAG_CMP_BASE) |
		({7'h00, overflow} << timer16_pkg::FLAG_OVF);
	wire [7:0] flagClr = wrFlags ? (wbyte & timer16_pkg::FLAG_MASK) : timer16_pkg::BYTE_RESET;

	// ==========================================================
	// Registers
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			ctrlA <= timer16_pkg::BYTE_RESET;
			ctrlB <= timer16_pkg::BYTE_RESET;
			intEn <= timer16_pkg::BYTE_RESET;
			temp <= timer16_pkg::BYTE_RESET;
		end else begin
			if (wrCtrlA) ctrlA <= wbyte;
			if (wrCtrlB) ctrlB <= wbyte & timer16_pkg::CTRL_B_WMASK;
			if (wrIntEn) intEn <= wbyte & timer16_pkg::FLAG_MASK;
			if (wrHigh) temp <= wbyte;
			else if (rdLatchLow) temp <= snapHigh;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cmpVal[0] <= 16'h0000;
			cmpVal[1] <= 16'h0000;
			cmpVal[2] <= 16'h0000;
			capValue <= 16'h0000;
		end else begin
			if (wrCmpAL) cmpVal[0] <= {temp, wbyte};
			if (wrCmpBL) cmpVal[1] <= {temp, wbyte};
			if (wrCmpCL) cmpVal[2] <= {temp, wbyte};
			if (wrCapL) capValue <= {temp, wbyte};
			else if (capEvent) capValue <= counter;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			counter <= 16'h0000;
			countUp <= 1'b1;
			presc <= 10'h000;
			extPrev <= 1'b0;
			blockMatch <= 1'b0;
			waveLevel <= 3'h0;
		end else begin
			counter <= next_counter;
			countUp <= next_countUp;
			presc <= presc + 10'h001;
			extPrev <= ext_count_pin;
			blockMatch <= wrCntL | (blockMatch & ~tick);
			waveLevel <= next_wave;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			capPrev <= 1'b0;
			capHist <= 4'h0;
			capFilt <= 1'b0;
			flags <= timer16_pkg::BYTE_RESET;
			intRequest <= 1'b0;
			compareOutEn <= 3'h0;
		end else begin
			capPrev <= capture_input_pin;
			capHist <= {capHist[2:0], capture_input_pin};
			if (filtRise | filtFall) capFilt <= capHist[3];
			flags <= (flags & ~flagClr) | flagSet;
			intRequest <= globalIntEn & |(flags & intEn);
			compareOutEn <= {|ctrlA[3:2], |ctrlA[5:4], |ctrlA[7:6]};
		end
	end

	// Read data is sampled in the setup cycle so the answer comes with zero wait states.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			apbRsp <= '0;
			snapHigh <= timer16_pkg::BYTE_RESET;
		end else begin
			apbRsp.pready <= setupPhase;
			apbRsp.pslverr <= setupPhase & ~mapped;
			if (setupPhase) apbRsp.prdata <= {24'h000000, readByte};
			if (setupPhase) snapHigh <= highOfLow;
		end
	end

	assign compare_output_a = waveLevel[0];
	assign compare_output_b = waveLevel[1];
	assign compare_output_c = waveLevel[2];

	// ==========================================================
	// Checks
	a_force_reads_zero: assert property (@(posedge clk) disable iff (rst)
		(rdEn && idx == timer16_pkg::IDX_FORCE) |-> apbRsp.prdata == 32'h0)
		else $error("force register read nonzero");
	a_reserved_bit_zero: assert property (@(posedge clk) disable iff (rst)
		wrCtrlB |=> ctrlB[5] == 1'b0)
		else $error("reserved control bit set");
	a_filter_delay: assert property (@(posedge clk) disable iff (rst)
		(capEvent && filterOn) |->
		($past(capture_input_pin, timer16_pkg::FILTER_LEN) == edgeLevel &&
		$past(capture_input_pin, 1) == edgeLevel && capFilt != edgeLevel))
		else $error("filtered capture too early");
	a_capture_copy: assert property (@(posedge clk) disable iff (rst)
		(capEvent && !wrCapL) |=> capValue == $past(counter))
		else $error("capture did not copy counter");
	a_capture_off: assert property (@(posedge clk) disable iff (rst)
		(capDisabled && !wrCapL) |=> capValue == $past(capValue))
		else $error("capture changed while ceiling source");
	a_stopped_count: assert property (@(posedge clk) disable iff (rst)
		(clkSel == timer16_pkg::CS_STOP && !wrCntL) |=> counter == $past(counter))
		else $error("stopped counter moved");
	a_div8_tick: assert property (@(posedge clk) disable iff (rst)
		(clkSel == timer16_pkg::CS_DIV8 && tick) |-> presc[2:0] == 3'h7)
		else $error("divide by eight tick misplaced");
	a_ext_fall: assert property (@(posedge clk) disable iff (rst)
		(clkSel == timer16_pkg::CS_EXT_FALL && tick) |-> (extPrev && !ext_count_pin))
		else $error("external tick without falling edge");
	a_write_blocks: assert property (@(posedge clk) disable iff (rst)
		(blockMatch && tick) |-> cmpHit == 3'h0)
		else $error("match after counter write not blocked");
	a_force_no_flag: assert property (@(posedge clk) disable iff (rst)
		(forceHit != 3'h0 && !tick && !wrCntL) |=> counter == $past(counter) &&
		(flags[3:1] & ~$past(flags[3:1])) == 3'h0)
		else $error("force strobe set flag or moved counter");
	a_pwm_no_force: assert property (@(posedge clk) disable iff (rst)
		(pwmMode && wrForce && !tick) |=> waveLevel == $past(waveLevel))
		else $error("force acted in PWM mode");
	a_force_toggle: assert property (@(posedge clk) disable iff (rst)
		(forceHit[0] && ctrlA[7:6] == 2'h1 && !cmpHit[0]) |=> waveLevel[0] != $past(waveLevel[0]))
		else $error("forced toggle missing");
	a_flag_sticky: assert property (@(posedge clk) disable iff (rst)
		capEvent |=> flags[timer16_pkg::FLAG_CAP])
		else $error("capture flag not set");
	a_int_gate: assert property (@(posedge clk) disable iff (rst)
		!globalIntEn |=> !intRequest)
		else $error("interrupt without global enable");
	a_atomic_write: assert property (@(posedge clk) disable iff (rst)
		wrCntL |=> counter == {$past(temp), $past(wbyte)})
		else $error("counter write not atomic");
	// Match checks start from the counter and compare values, not from the hit term.
	a_compare_flag: assert property (@(posedge clk) disable iff (rst)
		(tick && !blockMatch && !wrCntL && counter == cmpVal[0]) |=>
		flags[timer16_pkg::FLAG_CMP_BASE])
		else $error("compare match flag missing");
	a_clear_wrap: assert property (@(posedge clk) disable iff (rst)
		(tick && !wrCntL && (mode == 4'h4 || mode == 4'hc) && counter == cmpVal[0]) |=>
		counter == 16'h0000)
		else $error("clear on match did not wrap");
	a_capture_edge: assert property (@(posedge clk) disable iff (rst)
		(capEvent && !filterOn) |->
		(capture_input_pin == edgeLevel && $past(capture_input_pin) != edgeLevel))
		else $error("capture on wrong edge");
	a_int_raise: assert property (@(posedge clk) disable iff (rst)
		(globalIntEn && (flags & intEn) != 8'h00) |=> intRequest)
		else $error("interrupt request missing");
endmodule : timer16_capture_compare_ctrl

// >>> design/timer16_pkg.sv
// Shared constants and bus carrier types for the 16-bit timer control slice.
package timer16_pkg;
	// ==========================================================
	// Register word indices (byte address is four times the index)
	localparam logic [7:0] IDX_FLAGS = 8'h36;
	localparam logic [7:0] IDX_INT_EN = 8'h6f;
	localparam logic [7:0] IDX_CTRL_A = 8'h80;
	localparam logic [7:0] IDX_CTRL_B = 8'h81;
	localparam logic [7:0] IDX_FORCE = 8'h82;
	localparam logic [7:0] IDX_CNT_L = 8'h84;
	localparam logic [7:0] IDX_CNT_H = 8'h85;
	localparam logic [7:0] IDX_CAP_L = 8'h86;
	localparam logic [7:0] IDX_CAP_H = 8'h87;
	localparam logic [7:0] IDX_CMPA_L = 8'h88;
	localparam logic [7:0] IDX_CMPA_H = 8'h89;
	localparam logic [7:0] IDX_CMPB_L = 8'h8a;
	localparam logic [7:0] IDX_CMPB_H = 8'h8b;
	localparam logic [7:0] IDX_CMPC_L = 8'h8c;
	localparam logic [7:0] IDX_CMPC_H = 8'h8d;
	// ==========================================================
	// Field positions, masks and reset values
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam int FILTER_EN_POS = 7;
	localparam int EDGE_SEL_POS = 6;
	localparam logic [7:0] CTRL_B_WMASK = 8'hdf;
	localparam logic [7:0] FLAG_MASK = 8'h2f;
	localparam int FLAG_CAP = 5;
	localparam int FLAG_OVF = 0;
	localparam int FLAG_CMP_BASE = 1;
	localparam int FORCE_TOP_POS = 7;
	localparam int FILTER_LEN = 4;
	// ==========================================================
	// Clock select codes and count ceilings
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	localparam logic [15:0] TOP_8 = 16'h00ff;
	localparam logic [15:0] TOP_9 = 16'h01ff;
	localparam logic [15:0] TOP_10 = 16'h03ff;
	localparam logic [15:0] TOP_MAX = 16'hffff;
	// ==========================================================
	// APB carriers
	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} apb_req_t;
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} apb_rsp_t;
endpackage : timer16_pkg

// >>> tb/tb_top.sv
// Self-checking testbench for the 16-bit timer capture and compare slice.
`timescale 1ns/100ps
module tb_top;
	// ==========================================================
	// Signals
	logic clk = 1'b0;
	logic rst = 1'b1;
	timer16_pkg::apb_req_t apbReq = '0;
	timer16_pkg::apb_rsp_t apbRsp;
	logic capPin = 1'b0;
	logic extPin = 1'b0;
	logic globalIntEn = 1'b0;
	logic outA, outB, outC, intReq;
	logic [2:0] outEn;
	int badCount = 0;
	int nCompared = 0;
	int cyc = 0;
	int setupCyc = 0;
	int t0;
	logic lastErr;
	logic [7:0] d;
	logic [15:0] v0, v1;
	int divShift[6] = '{0, 0, 3, 6, 8, 10};
	logic [7:0] resetIdx[4] = '{timer16_pkg::IDX_CTRL_A, timer16_pkg::IDX_CTRL_B,
		timer16_pkg::IDX_FORCE, timer16_pkg::IDX_CMPA_H};

	always #4 clk = ~clk;
	always @(posedge clk) cyc <= cyc + 1;

	timer16_capture_compare_ctrl u_dut (
		.clk(clk), .rst(rst), .apbReq(apbReq), .apbRsp(apbRsp),
		.capture_input_pin(capPin), .ext_count_pin(extPin), .globalIntEn(globalIntEn),
		.compare_output_a(outA), .compare_output_b(outB), .compare_output_c(outC),
		.compareOutEn(outEn), .intRequest(intReq)
	);

	// ==========================================================
	// Tasks
	task automatic summarize();
		if (badCount == 0 && nCompared > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : summarize

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		nCompared++;
		if (got !== exp) begin
			badCount++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// One APB transfer; an idle cycle follows so that back-to-back calls never
	// assign psel twice in one time step.
	task automatic xfer(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
		output logic [7:0] rd);
		int n;
		n = 0;
		apbReq.psel <= 1'b1;
		apbReq.penable <= 1'b0;
		apbReq.pwrite <= wr;
		apbReq.paddr <= {2'b00, idx, 2'b00};
		apbReq.pwdata <= {24'h000000, wd};
		@(posedge clk);
		setupCyc = cyc;
		apbReq.penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (apbRsp.pready !== 1'b1 && n < 16);
		if (apbRsp.pready !== 1'b1) begin
			badCount++;
			summarize();
		end
		rd = apbRsp.prdata[7:0];
		lastErr = apbRsp.pslverr;
		apbReq.psel <= 1'b0;
		apbReq.penable <= 1'b0;
		@(posedge clk);
	endtask : xfer

	task automatic wr16(input logic [7:0] idxL, input logic [15:0] v);
		xfer(1'b1, idxL + 8'h01, v[15:8], d);
		xfer(1'b1, idxL, v[7:0], d);
	endtask : wr16

	task automatic rd16(input logic [7:0] idxL, output logic [15:0] v);
		int c;
		xfer(1'b0, idxL, 8'h00, v[7:0]);
		c = setupCyc;
		xfer(1'b0, idxL + 8'h01, 8'h00, v[15:8]);
		setupCyc = c;
	endtask : rd16

	task automatic capEdge(input logic level);
		capPin <= level;
		repeat (8) @(posedge clk);
	endtask : capEdge

	task automatic pulseExt(input int n);
		repeat (n) begin
			extPin <= 1'b1;
			repeat (3) @(posedge clk);
			extPin <= 1'b0;
			repeat (3) @(posedge clk);
		end
	endtask : pulseExt

	// ==========================================================
	// Watchdog
	initial begin
		#400000;
		badCount++;
		summarize();
	end

	// ==========================================================
	// Main sequence
	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		foreach (resetIdx[i]) begin
			xfer(1'b0, resetIdx[i], 8'h00, d);
			check("reset value", timer16_pkg::BYTE_RESET, d);
		end
		xfer(1'b1, timer16_pkg::IDX_CTRL_B, 8'h20, d);
		xfer(1'b0, timer16_pkg::IDX_CTRL_B, 8'h00, d);
		check("reserved bit", 16'h0000, d);
		xfer(1'b0, 8'h83, 8'h00, d);
		check("unmapped error", 16'h0001, lastErr);
		check("unmapped data", 16'h0000, d);
		wr16(timer16_pkg::IDX_CMPA_L, 16'h1234);
		xfer(1'b0, timer16_pkg::IDX_CMPA_H, 8'h00, d);
		check("compare a high", 16'h0012, d);
		xfer(1'b0, timer16_pkg::IDX_CMPA_L, 8'h00, d);
		check("compare a low", 16'h0034, d);
		wr16(timer16_pkg::IDX_CNT_L, 16'habcd);
		rd16(timer16_pkg::IDX_CNT_L, v0);
		check("counter readback", 16'habcd, v0);
		// Spacing of 1024 cycles is a multiple of every divider, so counts are exact.
		for (int cs = 0; cs < 6; cs++) begin
			xfer(1'b1, timer16_pkg::IDX_CTRL_B, 8'(cs), d);
			rd16(timer16_pkg::IDX_CNT_L, v0);
			t0 = setupCyc;
			repeat (t0 + 1023 - cyc) @(posedge clk);
			rd16(timer16_pkg::IDX_CNT_L, v1);
			check("prescaled count", (cs == 0) ? 16'h0000 : 16'(1024 >> divShift[cs]), v1 - v0);
		end
		for (int e = 0; e < 2; e++) begin
			xfer(1'b1, timer16_pkg::IDX_CTRL_B, {5'h00, (e == 1) ? timer16_pkg::CS_EXT_RISE :
				timer16_pkg::CS_EXT_FALL}, d);
			wr16(timer16_pkg::IDX_CNT_L, 16'h0000);
			pulseExt(5);
			rd16(timer16_pkg::IDX_CNT_L, v0);
			check("external count", 16'h0005, v0);
		end
		xfer(1'b1, timer16_pkg::IDX_CTRL_B, 8'h00, d);
		wr16(timer16_pkg::IDX_CNT_L, 16'h4000);
		xfer(1'b1, timer16_pkg::IDX_FLAGS, timer16_pkg::FLAG_MASK, d);
		xfer(1'b1, timer16_pkg::IDX_CTRL_A, 8'h6c, d);
		xfer(1'b1, timer16_pkg::IDX_FORCE, 8'he0, d);
		check("forced outputs", 16'h0005, {outC, outB, outA});
		check("output enables", 16'h0007, outEn);
		xfer(1'b0, timer16_pkg::IDX_FORCE, 8'h00, d);
		check("force readback", 16'h0000, d);
		xfer(1'b0, timer16_pkg::IDX_FLAGS, 8'h00, d);
		check("force flags", 16'h0000, d);
		rd16(timer16_pkg::IDX_CNT_L, v0);
		check("force counter", 16'h4000, v0);
		xfer(1'b1, timer16_pkg::IDX_FORCE, 8'h80, d);
		check("forced toggle", 16'h0004, {outC, outB, outA});
		xfer(1'b1, timer16_pkg::IDX_CTRL_A, 8'h6d, d);
		xfer(1'b1, timer16_pkg::IDX_FORCE, 8'he0, d);
		check("force in pwm", 16'h0004, {outC, outB, outA});
		xfer(1'b1, timer16_pkg::IDX_CTRL_A, 8'h00, d);
		xfer(1'b1, timer16_pkg::IDX_FLAGS, timer16_pkg::FLAG_MASK, d);
		wr16(timer16_pkg::IDX_CNT_L, 16'h0111);
		capEdge(1'b1);
		rd16(timer16_pkg::IDX_CAP_L, v0);
		check("rising ignored", 16'h0000, v0);
		capEdge(1'b0);
		rd16(timer16_pkg::IDX_CAP_L, v0);
		check("falling capture", 16'h0111, v0);
		xfer(1'b0, timer16_pkg::IDX_FLAGS, 8'h00, d);
		check("capture flag", 16'h0001, d[timer16_pkg::FLAG_CAP]);
		xfer(1'b1, timer16_pkg::IDX_CTRL_B, 8'h40, d);
		wr16(timer16_pkg::IDX_CNT_L, 16'h0222);
		capEdge(1'b1);
		rd16(timer16_pkg::IDX_CAP_L, v0);
		check("rising capture", 16'h0222, v0);
		xfer(1'b1, timer16_pkg::IDX_CTRL_B, 8'h80, d);
		wr16(timer16_pkg::IDX_CNT_L, 16'h0333);
		capPin <= 1'b0;
		repeat (2) @(posedge clk);
		capEdge(1'b1);
		rd16(timer16_pkg::IDX_CAP_L, v0);
		check("glitch filtered", 16'h0222, v0);
		capEdge(1'b0);
		rd16(timer16_pkg::IDX_CAP_L, v0);
		check("filtered capture", 16'h0333, v0);
		// Mode 0xE takes its ceiling from the capture register, so capture is off.
		xfer(1'b1, timer16_pkg::IDX_FLAGS, timer16_pkg::FLAG_MASK, d);
		xfer(1'b1, timer16_pkg::IDX_CTRL_A, 8'h02, d);
		xfer(1'b1, timer16_pkg::IDX_CTRL_B, 8'h18, d);
		capEdge(1'b1);
		capEdge(1'b0);
		xfer(1'b0, timer16_pkg::IDX_FLAGS, 8'h00, d);
		check("capture disabled", 16'h0000, d[timer16_pkg::FLAG_CAP]);
		xfer(1'b1, timer16_pkg::IDX_CTRL_A, 8'h00, d);
		xfer(1'b1, timer16_pkg::IDX_CTRL_B, 8'h00, d);
		xfer(1'b1, timer16_pkg::IDX_INT_EN, 8'h20, d);
		capEdge(1'b1);
		capEdge(1'b0);
		check("masked globally", 16'h0000, intReq);
		globalIntEn <= 1'b1;
		repeat (3) @(posedge clk);
		check("interrupt raised", 16'h0001, intReq);
		xfer(1'b1, timer16_pkg::IDX_FLAGS, 8'h20, d);
		repeat (3) @(posedge clk);
		check("interrupt cleared", 16'h0000, intReq);
		wr16(timer16_pkg::IDX_CMPA_L, 16'h0009);
		wr16(timer16_pkg::IDX_CNT_L, 16'h0000);
		xfer(1'b1, timer16_pkg::IDX_CTRL_B, 8'h09, d);
		repeat (4) begin
			rd16(timer16_pkg::IDX_CNT_L, v0);
			check("clear on match ceiling", 16'h0001, v0 <= 16'h0009);
		end
		// A counter write masks only the match on the next timer tick.
		xfer(1'b1, timer16_pkg::IDX_CTRL_B, 8'h0f, d);
		wr16(timer16_pkg::IDX_CNT_L, 16'h0009);
		xfer(1'b1, timer16_pkg::IDX_FLAGS, timer16_pkg::FLAG_MASK, d);
		pulseExt(1);
		xfer(1'b0, timer16_pkg::IDX_FLAGS, 8'h00, d);
		check("blocked match", 16'h0000, d[timer16_pkg::FLAG_CMP_BASE]);
		rd16(timer16_pkg::IDX_CNT_L, v0);
		check("wrap at ceiling", 16'h0000, v0);
		pulseExt(10);
		xfer(1'b0, timer16_pkg::IDX_FLAGS, 8'h00, d);
		check("compare match", 16'h0001, d[timer16_pkg::FLAG_CMP_BASE]);
		summarize();
	end
endmodule : tb_top
